// ==== inc/itest_pkg.sv ====
// Package for the integration-test register block.
// Assumes a 32-bit word-addressed debug register port, 4KB window.
package itest_pkg;

  // ****************************************************************
  // Register map (word addresses within the lower 4KB debug region)
  // ****************************************************************
  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_MISC_OUTPUT_TEST = 10'h3B7;
  localparam logic [9:0] ADDR_MISC_INPUT_TEST = 10'h3B8;
  localparam logic [9:0] ADDR_MODE_CONTROL = 10'h3C0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MODE_BIT = 0;
  localparam int OUT_RESTART_DONE_BIT = 9;
  localparam int OUT_PERF_IRQ_BIT = 4;
  localparam int OUT_DEBUG_ACK_BIT = 0;
  localparam int IN_RESTART_REQ_BIT = 11;
  localparam int IN_FAST_IRQ_BIT = 2;
  localparam int IN_NORMAL_IRQ_BIT = 1;
  localparam int IN_EXT_DBG_REQ_BIT = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_MODE = 1'h0;
  localparam logic [2:0] RST_TEST_OUT = 3'h0;
  localparam logic [31:0] RST_RDATA = 32'h0;
  localparam logic [3:0] RST_SYNC_IN = 4'hF;

  // Three controlled outputs travel together
  typedef struct packed {
    logic restart_done;
    logic perf_irq;
    logic debug_ack;
  } misc_out_type;

  // Four observed inputs travel together
  typedef struct packed {
    logic restart_req;
    logic fast_irq_n;
    logic normal_irq_n;
    logic ext_dbg_req;
  } misc_in_type;

endpackage

// ==== design/pin_sync.sv ====
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to i_clk_sys.
module pin_sync
  import itest_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic i_clk_sys, // System clock
  input wire logic i_resetn, // Synchronous reset, low
  input wire logic i_ce, // Clock enable
  input wire logic [WIDTH-1:0] i_async, // Raw pins
  output logic [WIDTH-1:0] o_sync // Synchronised pins
);

  logic [WIDTH-1:0] stage1_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      stage1_r <= RESET_VAL;
      o_sync <= RESET_VAL;
    end
    else if (i_ce)
    begin
      stage1_r <= i_async;
      o_sync <= stage1_r;
    end
  end

endmodule

// ==== design/integration_test_regs.sv ====
// Integration-test registers: mode control, pin drive and pin sampling.
// Assumes a simple 32-bit register port, one-cycle write/read strobes.
//
// Contract
// - Mode bit zero: functional or integration
// - Reset to functional mode; software enters
// - Mode register always accessible; upper bits reserved
// - Output register write drives three pins in integration mode only
// - Pin level equals written bit value
// - Input register reads restart and debug request in integration mode only
// - Bits two and one read interrupt pins
// - 32-bit memory-mapped port, 4KB debug region
module integration_test_regs
  import itest_pkg::*;
(
  input wire logic i_clk_sys, // System clock, 125 MHz
  input wire logic i_resetn, // Synchronous reset, low
  input wire logic i_ce, // Clock enable, freezes state
  input wire logic i_sel, // Register access select
  input wire logic i_write, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] i_addr, // Word address
  input wire logic [31:0] i_wdata, // Write data
  output logic [31:0] o_rdata, // Read data, valid with o_ready
  output logic o_ready, // Access done pulse
  input wire misc_out_type i_func_out, // Functional pin values
  output misc_out_type o_pins_out, // Driven output pins
  input wire logic i_restart_request_in, // Restart request pin
  input wire logic i_fast_irq_n_in, // Fast interrupt pin, low
  input wire logic i_normal_irq_n_in, // Normal interrupt pin, low
  input wire logic i_external_debug_request_in, // Debug request pin
  output misc_in_type o_pins_in, // Synchronised inputs to core
  output logic o_integration_mode_enable // Mode bit
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  misc_in_type in_sync;

  pin_sync #(
    .WIDTH(4),
    .RESET_VAL(RST_SYNC_IN)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_async({i_restart_request_in, i_fast_irq_n_in,
              i_normal_irq_n_in, i_external_debug_request_in}),
    .o_sync(in_sync)
  );

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic wr_mode, wr_out, rd_access;

  // Mode register needs no precondition
  assign wr_mode = i_sel && i_write && (i_addr == ADDR_MODE_CONTROL);
  // Test output writes take effect only in integration mode
  assign wr_out = i_sel && i_write && (i_addr == ADDR_MISC_OUTPUT_TEST)
                  && o_integration_mode_enable;
  assign rd_access = i_sel && !i_write;

  // ****************************************************************
  // Mode control
  // ****************************************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      o_integration_mode_enable <= RST_MODE;
    else if (i_ce && wr_mode)
      o_integration_mode_enable <= i_wdata[MODE_BIT];
  end

  // ****************************************************************
  // Test output register
  // ****************************************************************
  misc_out_type test_out_r;

  // Reserved bits are discarded, so non-zero writes are harmless
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      test_out_r <= RST_TEST_OUT;
    else if (i_ce && wr_out)
    begin
      test_out_r.restart_done <= i_wdata[OUT_RESTART_DONE_BIT];
      test_out_r.perf_irq <= i_wdata[OUT_PERF_IRQ_BIT];
      test_out_r.debug_ack <= i_wdata[OUT_DEBUG_ACK_BIT];
    end
  end

  // Output mux registered; written value reaches pins next cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      o_pins_out <= RST_TEST_OUT;
    else if (i_ce)
    begin
      if (!o_integration_mode_enable)
        o_pins_out <= i_func_out;
      else if (wr_out)
      begin
        o_pins_out.restart_done <= i_wdata[OUT_RESTART_DONE_BIT];
        o_pins_out.perf_irq <= i_wdata[OUT_PERF_IRQ_BIT];
        o_pins_out.debug_ack <= i_wdata[OUT_DEBUG_ACK_BIT];
      end
      else
        o_pins_out <= test_out_r;
    end
  end

  // Core sees inputs always; test reads do not disturb them
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      o_pins_in <= RST_SYNC_IN;
    else if (i_ce)
      o_pins_in <= in_sync;
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] rd_nxt;

  always_comb
  begin
    rd_nxt = RST_RDATA;
    if (i_addr == ADDR_MODE_CONTROL)
      rd_nxt[MODE_BIT] = o_integration_mode_enable;
    else if (i_addr == ADDR_MISC_INPUT_TEST && o_integration_mode_enable)
    begin
      // Undefined reserved bits read as zero here
      rd_nxt[IN_RESTART_REQ_BIT] = in_sync.restart_req;
      rd_nxt[IN_FAST_IRQ_BIT] = in_sync.fast_irq_n;
      rd_nxt[IN_NORMAL_IRQ_BIT] = in_sync.normal_irq_n;
      rd_nxt[IN_EXT_DBG_REQ_BIT] = in_sync.ext_dbg_req;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_rdata <= RST_RDATA;
      o_ready <= 1'b0;
    end
    else if (i_ce)
    begin
      o_ready <= i_sel;
      if (rd_access)
        o_rdata <= rd_nxt;
    end
  end

endmodule

// ==== dv/itest_props.sv ====
// Checker for the integration-test register block.
// Assumes i_ce is held high by its surroundings.
module itest_props
  import itest_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_sel,
  input wire logic i_write,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] o_rdata,
  input wire logic o_ready,
  input wire misc_out_type i_func_out,
  input wire misc_out_type o_pins_out,
  input wire misc_in_type o_pins_in,
  input wire logic o_integration_mode_enable
);
  wire wr = i_sel & i_write;
  wire rd = i_sel & ~i_write;
  wire md = o_integration_mode_enable;
  wire am = i_addr == ADDR_MODE_CONTROL;
  wire ao = i_addr == ADDR_MISC_OUTPUT_TEST;
  wire ai = i_addr == ADDR_MISC_INPUT_TEST;
  wire [2:0] wv = {i_wdata[9], i_wdata[4], i_wdata[0]};
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  a_ready_once: assert property (1'b1 |=> o_ready == $past(i_sel))
    else $error("ready");
  a_mode_set: assert property (wr && am |=> md == $past(i_wdata[0]))
    else $error("mode set");
  a_mode_keep: assert property (!(wr && am) |=> $stable(md))
    else $error("mode kept");
  a_mode_read: assert property (rd && am |=> o_rdata[0] == $past(md))
    else $error("mode read");
  a_out_drive: assert property (wr && ao && md |=>
    o_pins_out == $past(wv)) else $error("out drive");
  a_func_pass: assert property (!md |=>
    o_pins_out == $past(i_func_out)) else $error("func pass");
  a_in_read: assert property (rd && ai && md |=>
    o_rdata[11] == o_pins_in[3] && o_rdata[2:0] == o_pins_in[2:0])
    else $error("in read");
  a_in_fenced: assert property (rd && ai && !md |=> o_rdata == 32'h0)
    else $error("in fenced");
  c_out: cover property (wr && ao && md);
  c_in: cover property (rd && ai && md);
  c_leave: cover property ($fell(md));
endmodule

// ==== dv/dbg_host.sv ====
// Debug host model: one-word accesses, select for one cycle.
// Assumes the device takes its port on the rising edge.
module dbg_host
  import itest_pkg::*;
(
  input wire logic i_clk_sys, // Clock
  input wire logic [31:0] i_rdata, // Read data
  output logic o_sel = 1'b0, // Access select
  output logic o_write = 1'b0, // Write flag
  output logic [ADDR_W-1:0] o_addr = '0, // Word address
  output logic [31:0] o_wdata = '0 // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released address and data are inverted so a stale value cannot pass
  task automatic rw(input logic w, input logic [ADDR_W-1:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(negedge i_clk_sys);
    {o_sel, o_write, o_addr, o_wdata} = {1'b1, w, a, d};
    @(negedge i_clk_sys);
    {o_sel, o_addr, o_wdata} = {1'b0, ~a, ~d};
    q = i_rdata;
  endtask
endmodule

// ==== dv/test_integration_test_regs.sv ====
// Bench for the integration-test register block.
// Assumes the host model and the bound checker.
module test_integration_test_regs
  import itest_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 1'b0, i_resetn = 1'b0, i_sel, i_write, o_ready;
  logic o_integration_mode_enable;
  logic [ADDR_W-1:0] i_addr;
  logic [31:0] i_wdata, o_rdata, q, v;
  logic [15:0] lf = 16'hDEEE;
  logic [3:0] pin = 4'h0;
  misc_out_type i_func_out = 3'h0, o_pins_out;
  misc_in_type o_pins_in;
  int error_cnt = 0, checked = 0;
  integration_test_regs uut (.*, .i_ce(1'b1),
    .i_restart_request_in(pin[3]), .i_fast_irq_n_in(pin[2]),
    .i_normal_irq_n_in(pin[1]), .i_external_debug_request_in(pin[0]));
  dbg_host dbg (.i_clk_sys, .i_rdata(o_rdata), .o_sel(i_sel),
    .o_write(i_write), .o_addr(i_addr), .o_wdata(i_wdata));
  initial
  begin
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // The run needs about 100 cycles; ten times that means a hang
  initial
  begin
    repeat (1000) @(posedge i_clk_sys);
    error_cnt++;
    test_done();
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  initial
  begin
    repeat (4) @(negedge i_clk_sys);
    i_resetn = 1'b1;
    i_func_out = 3'h5;
    dbg.rw(1'b1, ADDR_MISC_OUTPUT_TEST, 32'h211, q);
    chk("pins", o_pins_out, 3'h5);
    chk("ready", o_ready, 1'b1);
    dbg.rw(1'b1, 10'h000, 32'h1, q);
    dbg.rw(1'b0, ADDR_MISC_INPUT_TEST, 32'h0, q);
    chk("in", q, 32'h0);
    dbg.rw(1'b0, ADDR_MODE_CONTROL, 32'h0, q);
    chk("mode", q, 32'h0);
    // Processor taken as halted before the mode is set
    dbg.rw(1'b1, ADDR_MODE_CONTROL, 32'h1, q);
    dbg.rw(1'b0, ADDR_MODE_CONTROL, 32'h0, q);
    chk("mode", q[0], 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      lf = step(lf);
      pin = lf[3:0];
      i_func_out = lf[6:4];
      v = i ? {16'h0, lf & 16'h0211} : 32'h211;
      dbg.rw(1'b1, ADDR_MISC_OUTPUT_TEST, v, q);
      chk("pins", o_pins_out, {v[9], v[4], v[0]});
      dbg.rw(1'b0, ADDR_MISC_INPUT_TEST, 32'h0, q);
      chk("in", q, {20'h0, pin[3], 8'h0, pin[2:0]});
      chk("core in", o_pins_in, pin);
    end
    dbg.rw(1'b1, ADDR_MODE_CONTROL, 32'h0, q);
    dbg.rw(1'b0, 10'h000, 32'h0, q);
    chk("unmapped", q, 32'h0);
    chk("pins", o_pins_out, i_func_out);
    dbg.rw(1'b1, ADDR_MODE_CONTROL, 32'h1, q);
    dbg.rw(1'b1, ADDR_MISC_OUTPUT_TEST, 32'h211, q);
    // System reset after integration testing
    i_resetn = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    i_resetn = 1'b1;
    chk("mode", o_integration_mode_enable, 1'b0);
    chk("pins", o_pins_out, 3'h0);
    dbg.rw(1'b0, ADDR_MODE_CONTROL, 32'h0, q);
    chk("mode", q, 32'h0);
    test_done();
  end
endmodule
bind integration_test_regs itest_props props (.*);
